// ---- src/lem_pkg.sv ----
// package: register map, field positions, timing and carrier types
package lem_pkg;
    localparam logic [7:0] ADDR_DETECTED = 8'h10;
    localparam logic [7:0] ADDR_CORRECTED = 8'h12;
    localparam logic [7:0] ADDR_TEST_ERR = 8'h13;
    localparam logic [7:0] ADDR_CONFIG = 8'h08;
    localparam logic [7:0] ADDR_THRESH_DET = 8'h11;
    localparam logic [7:0] ADDR_THRESH_COR = 8'h14;
    localparam logic [7:0] ADDR_STATUS = 8'h15;
    localparam int AUTO_CLEAR_BIT = 2;
    localparam int SERIAL_EN_BIT = 4;
    localparam int TEST_MODE_BIT = 5;
    localparam logic [7:0] CONFIG_RESET = 8'h00;
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [7:0] THRESH_RESET = 8'h00;
    localparam int CLK_HZ = 20000000;
    localparam int AUTO_CLEAR_NS = 1000;
    localparam int AUTO_CLEAR_CYC = (AUTO_CLEAR_NS * (CLK_HZ / 1000000)) / 1000;
    localparam int WIN_LEN = 16;
    localparam int WIN_LIMIT = WIN_LEN / 4;

    typedef struct packed {
        logic code_ok;
        logic det_err;
        logic cor_err;
        logic test_err;
    } lem_evt_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [7:0] addr;
        logic [7:0] wdata;
    } lem_reg_req_t;

    typedef enum logic [1:0] {
        LK_IDLE = 2'b00,
        LK_SEEK = 2'b01,
        LK_LOCKED = 2'b11,
        LK_DROP = 2'b10
    } lem_lock_t;
endpackage : lem_pkg

// ---- src/lem_link_error_monitor.sv ----
// module: serial-link error counters, error pin, auto clear and lock state
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - two 8-bit error counts: detected errors and corrected errors
// - code error rate of one in four drops lock, freezes counting
// - after dropping lock, automatically seek lock again
// - counts clear on video lock, on their read, or auto clear
// - test mode tallies test errors apart, normal counts held zero
// - error pin low once a count exceeds its threshold
// - in test mode, error pin low after one test bit error
// - error pin released whenever the counts are cleared
// - default clearing is by reading 0x10, 0x12 and 0x13
// - auto clear zeroes counts and pin about 1 us after pin low
// - auto clear off after reset, enabled by config bit 2
// - auto clear suppressed while test mode runs
// - error pin is open drain: drives low or floats
// - lock output asserts whenever lock is held; CFG_LINK_LOCK is not used
module lem_link_error_monitor #(
    parameter int WINDOW = lem_pkg::WIN_LEN,
    parameter int AUTO_CYC = lem_pkg::AUTO_CLEAR_CYC
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic SYM_VALID,
    input wire logic CODE_ERR,
    input wire logic DET_ERR,
    input wire logic COR_ERR,
    input wire logic TEST_BIT_ERR,
    input wire logic SIGNAL_SEEN,
    input wire logic CFG_LINK_LOCK,
    input wire logic REG_RD,
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    output logic [7:0] REG_RDATA,
    output logic ERR_N_OUT,
    output logic ERR_N_OE_N,
    output logic LOCK,
    output logic RELOCK_REQ
);
    initial
    begin
        if (WINDOW < 4 || WINDOW > 255 || AUTO_CYC < 1 || AUTO_CYC > 65535)
            $error("lem_link_error_monitor: unsupported parameters");
    end

    // ----------------------------------------------------------------
    // request and event bundles
    // ----------------------------------------------------------------
    lem_pkg::lem_reg_req_t req;
    lem_pkg::lem_evt_t evt;
    assign req = '{rd: REG_RD, wr: REG_WR, addr: REG_ADDR,
                   wdata: REG_WDATA};
    assign evt = '{code_ok: SYM_VALID && !CODE_ERR, det_err: DET_ERR,
                   cor_err: COR_ERR, test_err: TEST_BIT_ERR};

    logic [7:0] config_ff, nxt_config;
    logic [7:0] thr_det_ff, nxt_thr_det;
    logic [7:0] thr_cor_ff, nxt_thr_cor;
    logic [7:0] det_ff, nxt_det;
    logic [7:0] cor_ff, nxt_cor;
    logic [7:0] test_ff, nxt_test;
    logic [7:0] rdata_ff, nxt_rdata;
    logic err_ff, nxt_err;
    logic [15:0] auto_ff, nxt_auto;
    lem_pkg::lem_lock_t lock_st_ff, nxt_lock_st;
    logic [7:0] win_cnt_ff, nxt_win_cnt;
    logic [7:0] win_err_ff, nxt_win_err;
    logic lock_out_ff, nxt_lock_out;
    logic relock_ff, nxt_relock;

    logic test_mode;
    logic serial_en;
    logic auto_en;
    logic video_locked;
    logic lock_event;
    logic rd_det;
    logic rd_cor;
    logic rd_test;
    logic auto_fire;
    logic clear_all;

    assign test_mode = config_ff[lem_pkg::TEST_MODE_BIT];
    assign serial_en = config_ff[lem_pkg::SERIAL_EN_BIT];
    assign auto_en = config_ff[lem_pkg::AUTO_CLEAR_BIT];
    assign video_locked = (lock_st_ff == lem_pkg::LK_LOCKED);
    assign lock_event = (nxt_lock_st == lem_pkg::LK_LOCKED) && !video_locked;
    assign rd_det = req.rd && (req.addr == lem_pkg::ADDR_DETECTED);
    assign rd_cor = req.rd && (req.addr == lem_pkg::ADDR_CORRECTED);
    assign rd_test = req.rd && (req.addr == lem_pkg::ADDR_TEST_ERR);
    // no auto clear in test mode
    assign auto_fire = auto_en && !test_mode && err_ff &&
                       (auto_ff == 16'(AUTO_CYC - 1));
    assign clear_all = lock_event || auto_fire;

    // ----------------------------------------------------------------
    // lock tracking
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_lock_st = lock_st_ff;
        nxt_win_cnt = win_cnt_ff;
        nxt_win_err = win_err_ff;
        nxt_relock = 1'b0;
        case (lock_st_ff)
            lem_pkg::LK_IDLE:
                if (serial_en)
                    nxt_lock_st = lem_pkg::LK_SEEK;
            lem_pkg::LK_SEEK:
                if (!serial_en)
                    nxt_lock_st = lem_pkg::LK_IDLE;
                else if (SIGNAL_SEEN)
                    nxt_lock_st = lem_pkg::LK_LOCKED;
            lem_pkg::LK_LOCKED:
            begin
                if (!serial_en)
                    nxt_lock_st = lem_pkg::LK_IDLE;
                else if (SYM_VALID)
                begin
                    nxt_win_err = win_err_ff + 8'(CODE_ERR);
                    nxt_win_cnt = win_cnt_ff + 8'h01;
                    // error rate of 1/4 drops lock
                    if (nxt_win_err >= 8'(WINDOW / 4))
                        nxt_lock_st = lem_pkg::LK_DROP;
                    if (nxt_win_cnt >= 8'(WINDOW) ||
                        nxt_lock_st == lem_pkg::LK_DROP)
                    begin
                        nxt_win_cnt = 8'h00;
                        nxt_win_err = 8'h00;
                    end
                end
            end
            lem_pkg::LK_DROP:
            begin
                nxt_relock = 1'b1;
                nxt_lock_st = lem_pkg::LK_SEEK;
            end
            default:
                nxt_lock_st = lem_pkg::LK_IDLE;
        endcase
        nxt_lock_out = (nxt_lock_st == lem_pkg::LK_LOCKED);
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            lock_st_ff <= lem_pkg::LK_IDLE;
            win_cnt_ff <= 8'h00;
            win_err_ff <= 8'h00;
            lock_out_ff <= 1'b0;
            relock_ff <= 1'b0;
        end
        else
        begin
            lock_st_ff <= nxt_lock_st;
            win_cnt_ff <= nxt_win_cnt;
            win_err_ff <= nxt_win_err;
            lock_out_ff <= nxt_lock_out;
            relock_ff <= nxt_relock;
        end
    end

    // ----------------------------------------------------------------
    // error counts, error pin, auto clear
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_det = det_ff;
        nxt_cor = cor_ff;
        nxt_test = test_ff;
        nxt_err = err_ff;
        nxt_auto = 16'h0000;
        if (test_mode)
        begin
            nxt_det = lem_pkg::COUNT_RESET;
            nxt_cor = lem_pkg::COUNT_RESET;
            if (evt.test_err && test_ff != 8'hFF)
                nxt_test = test_ff + 8'h01;
            if (rd_test)
                nxt_test = lem_pkg::COUNT_RESET;
            nxt_err = (nxt_test != 8'h00);
        end
        else
        begin
            if (video_locked && evt.det_err && det_ff != 8'hFF)
                nxt_det = det_ff + 8'h01;
            if (video_locked && evt.cor_err && cor_ff != 8'hFF)
                nxt_cor = cor_ff + 8'h01;
            // clear on read, lock or auto
            if (rd_det || clear_all)
                nxt_det = lem_pkg::COUNT_RESET;
            if (rd_cor || clear_all)
                nxt_cor = lem_pkg::COUNT_RESET;
            if (rd_test)
                nxt_test = lem_pkg::COUNT_RESET;
            if (nxt_det > thr_det_ff || nxt_cor > thr_cor_ff)
                nxt_err = 1'b1;
            if (rd_det || rd_cor || rd_test || clear_all)
                nxt_err = 1'b0;
            if (err_ff && auto_en && !auto_fire)
                nxt_auto = auto_ff + 16'h0001;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            det_ff <= lem_pkg::COUNT_RESET;
            cor_ff <= lem_pkg::COUNT_RESET;
            test_ff <= lem_pkg::COUNT_RESET;
            err_ff <= 1'b0;
            auto_ff <= 16'h0000;
        end
        else
        begin
            det_ff <= nxt_det;
            cor_ff <= nxt_cor;
            test_ff <= nxt_test;
            err_ff <= nxt_err;
            auto_ff <= nxt_auto;
        end
    end

    // ----------------------------------------------------------------
    // register access
    // ----------------------------------------------------------------
    always_comb
    begin
        nxt_config = config_ff;
        nxt_thr_det = thr_det_ff;
        nxt_thr_cor = thr_cor_ff;
        nxt_rdata = rdata_ff;
        if (req.wr)
        begin
            if (req.addr == lem_pkg::ADDR_CONFIG)
                nxt_config = req.wdata;
            else if (req.addr == lem_pkg::ADDR_THRESH_DET)
                nxt_thr_det = req.wdata;
            else if (req.addr == lem_pkg::ADDR_THRESH_COR)
                nxt_thr_cor = req.wdata;
        end
        if (req.rd)
        begin
            if (req.addr == lem_pkg::ADDR_DETECTED)
                nxt_rdata = det_ff;
            else if (req.addr == lem_pkg::ADDR_CORRECTED)
                nxt_rdata = cor_ff;
            else if (req.addr == lem_pkg::ADDR_TEST_ERR)
                nxt_rdata = test_ff;
            else if (req.addr == lem_pkg::ADDR_CONFIG)
                nxt_rdata = config_ff;
            else if (req.addr == lem_pkg::ADDR_THRESH_DET)
                nxt_rdata = thr_det_ff;
            else if (req.addr == lem_pkg::ADDR_THRESH_COR)
                nxt_rdata = thr_cor_ff;
            else if (req.addr == lem_pkg::ADDR_STATUS)
                nxt_rdata = {5'h00, err_ff, lock_st_ff};
            else
                nxt_rdata = 8'h00;
        end
    end

    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
        begin
            config_ff <= lem_pkg::CONFIG_RESET;
            thr_det_ff <= lem_pkg::THRESH_RESET;
            thr_cor_ff <= lem_pkg::THRESH_RESET;
            rdata_ff <= 8'h00;
        end
        else
        begin
            config_ff <= nxt_config;
            thr_det_ff <= nxt_thr_det;
            thr_cor_ff <= nxt_thr_cor;
            rdata_ff <= nxt_rdata;
        end
    end

    assign ERR_N_OUT = 1'b0;
    always_ff @(posedge CLK or posedge RST)
    begin
        if (RST)
            ERR_N_OE_N <= 1'b1;
        else
            ERR_N_OE_N <= !nxt_err;
    end

    assign REG_RDATA = rdata_ff;
    assign LOCK = lock_out_ff;
    assign RELOCK_REQ = relock_ff;

    logic unused_ok;
    assign unused_ok = evt.code_ok ^ CFG_LINK_LOCK;
endmodule : lem_link_error_monitor

`default_nettype wire

// ---- verification/lem_chk.sv ----
// checker: port-level assertions of the link error monitor
`timescale 1ns/1ps
`default_nettype none
module lem_chk #(
    parameter int AUTO_CYC = 20
) (
    input wire logic CLK,
    input wire logic RST,
    input wire logic SIGNAL_SEEN,
    input wire logic TEST_BIT_ERR,
    input wire logic REG_RD,
    input wire logic REG_WR,
    input wire logic [7:0] REG_ADDR,
    input wire logic [7:0] REG_WDATA,
    input wire logic ERR_N_OUT,
    input wire logic ERR_N_OE_N,
    input wire logic LOCK,
    input wire logic RELOCK_REQ
);
    localparam int AC_LO = AUTO_CYC - 1;
    localparam int AC_HI = AUTO_CYC + 1;
    logic [7:0] cfg_ff;
    logic [7:0] nxt_cfg;
    logic tst;
    logic aut;
    // shadow of the config register, seen from the bus side
    assign nxt_cfg = (REG_WR && REG_ADDR == lem_pkg::ADDR_CONFIG) ?
        REG_WDATA : cfg_ff;
    assign tst = cfg_ff[lem_pkg::TEST_MODE_BIT];
    assign aut = cfg_ff[lem_pkg::AUTO_CLEAR_BIT];
    always_ff @(posedge CLK or posedge RST)
        if (RST)
            cfg_ff <= 8'h00;
        else
            cfg_ff <= nxt_cfg;
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    drive_low_only_a: assert property (ERR_N_OUT == 1'b0)
        else $error("pin data not low");
    pin_on_test_a: assert property (tst && TEST_BIT_ERR && !REG_RD
        |=> !ERR_N_OE_N) else $error("test error missed");
    auto_release_a: assert property ($fell(ERR_N_OE_N) && aut && !tst
        |-> ##[AC_LO:AC_HI] ERR_N_OE_N) else $error("auto clear late");
    test_hold_a: assert property ($fell(ERR_N_OE_N) && tst
        |-> ##AC_HI !ERR_N_OE_N) else $error("auto clear in test");
    read_release_a: assert property (REG_RD && !tst &&
        REG_ADDR == lem_pkg::ADDR_DETECTED |=> ERR_N_OE_N)
        else $error("count read kept pin");
    test_read_a: assert property (REG_RD && tst &&
        REG_ADDR == lem_pkg::ADDR_TEST_ERR |=> ERR_N_OE_N)
        else $error("test read kept pin");
    lock_clear_a: assert property ($rose(LOCK) |-> ##[0:1] ERR_N_OE_N)
        else $error("pin low after lock");
    lock_source_a: assert property ($rose(LOCK) |->
        $past(SIGNAL_SEEN) || $past(SIGNAL_SEEN, 2))
        else $error("lock without signal");
    relock_pulse_a: assert property (RELOCK_REQ |->
        !LOCK ##1 !RELOCK_REQ) else $error("bad relock pulse");
endmodule : lem_chk
bind lem_link_error_monitor lem_chk #(.AUTO_CYC(AUTO_CYC)) i_lem_chk (
    .CLK(CLK), .RST(RST), .SIGNAL_SEEN(SIGNAL_SEEN),
    .TEST_BIT_ERR(TEST_BIT_ERR), .REG_RD(REG_RD), .REG_WR(REG_WR),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .ERR_N_OUT(ERR_N_OUT),
    .ERR_N_OE_N(ERR_N_OE_N), .LOCK(LOCK), .RELOCK_REQ(RELOCK_REQ));
`default_nettype wire

// ---- verification/lem_mcu.sv ----
// partner: control-channel master reading and writing the registers
`timescale 1ns/1ps
`default_nettype none
module lem_mcu (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output var lem_pkg::lem_reg_req_t req
);
    initial req = '0;
    // one-cycle strobe, then release and take the answer
    task automatic access(input logic w, input logic [7:0] a,
        input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        req = '{rd: !w, wr: w, addr: a, wdata: d};
        @(negedge clk);
        req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        q = rdata;
    endtask : access
endmodule : lem_mcu
`default_nettype wire

// ---- verification/link_error_monitor_tb_top.sv ----
// testbench: random and corner-case traffic for the link error monitor
`timescale 1ns/1ps
`default_nettype none
module link_error_monitor_tb_top;
    localparam lem_pkg::lem_evt_t e_det = 4'h4;
    localparam lem_pkg::lem_evt_t e_cor = 4'h2;
    localparam lem_pkg::lem_evt_t e_tst = 4'h1;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic sym = 1'b0;
    logic cerr = 1'b0;
    logic seen = 1'b0;
    logic cfg_lk = 1'b0;
    logic dropped = 1'b0;
    lem_pkg::lem_evt_t ev = '0;
    lem_pkg::lem_reg_req_t req;
    logic [7:0] rdata;
    logic [7:0] q;
    logic err_out;
    logic err_oe_n;
    logic lock;
    logic relock;
    logic [15:0] lfsr = 16'hB1C3;
    int n;
    int n_fail = 0;
    int checks_done = 0;
    initial forever #25 clk = ~clk;
    lem_link_error_monitor #(.WINDOW(16), .AUTO_CYC(20))
        i_lem_link_error_monitor (.CLK(clk), .RST(rst), .SYM_VALID(sym),
        .CODE_ERR(cerr), .DET_ERR(ev.det_err), .COR_ERR(ev.cor_err),
        .TEST_BIT_ERR(ev.test_err), .SIGNAL_SEEN(seen),
        .CFG_LINK_LOCK(cfg_lk), .REG_RD(req.rd), .REG_WR(req.wr),
        .REG_ADDR(req.addr), .REG_WDATA(req.wdata), .REG_RDATA(rdata),
        .ERR_N_OUT(err_out), .ERR_N_OE_N(err_oe_n), .LOCK(lock),
        .RELOCK_REQ(relock));
    lem_mcu i_lem_mcu (.clk(clk), .rdata(rdata), .req(req));
    always @(posedge clk)
        if (relock)
            dropped <= 1'b1;
    function automatic logic [15:0] step(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : step
    function automatic logic [7:0] exp_cnt(input int k);
        return (k > 255) ? 8'hFF : k[7:0];
    endfunction : exp_cnt
    function automatic logic [7:0] pin();
        return {7'h00, err_oe_n};
    endfunction : pin
    task automatic check(input logic [7:0] seen_v, input logic [7:0] exp,
        input string what);
        checks_done++;
        if (seen_v !== exp)
        begin
            n_fail++;
            $display("ERROR %s expected %h seen %h", what, exp, seen_v);
        end
    endtask : check
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : tally_and_finish
    task automatic pulse(input int k, input lem_pkg::lem_evt_t e);
        repeat (k)
        begin
            @(negedge clk);
            ev = e;
        end
        @(negedge clk);
        ev = '0;
    endtask : pulse
    task automatic rd(input logic [7:0] a);
        i_lem_mcu.access(1'b0, a, 8'h00, q);
    endtask : rd
    task automatic wait_hi(input bit on_drop);
        n = 0;
        while ((on_drop ? dropped : lock) !== 1'b1 && n < 99)
        begin
            @(negedge clk);
            n++;
        end
        check({7'h00, on_drop ? dropped : lock}, 8'h01, "wait");
        if ((on_drop ? dropped : lock) !== 1'b1)
            tally_and_finish();
    endtask : wait_hi
    initial
    begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        cfg_lk = 1'b1;
        rd(lem_pkg::ADDR_CORRECTED);
        check(q, lem_pkg::COUNT_RESET, "cor reset");
        check({6'h00, err_out, lock}, 8'h00, "idle");
        check(pin(), 8'h01, "pin idle");
        i_lem_mcu.access(1'b1, lem_pkg::ADDR_THRESH_DET, 8'h03, q);
        i_lem_mcu.access(1'b1, lem_pkg::ADDR_CONFIG, 8'h10, q);
        seen = 1'b1;
        wait_hi(1'b0);
        for (int i = 0; i < 4; i++)
        begin
            lfsr = step(lfsr);
            n = (i < 2) ? i + 3 : int'(lfsr[2:0]) + 1;
            pulse(n, e_det);
            check(pin(), (n > 3) ? 8'h00 : 8'h01, "pin det");
            rd(lem_pkg::ADDR_DETECTED);
            check(q, exp_cnt(n), "det");
            check(pin(), 8'h01, "pin read");
            n = int'(lfsr[4:3]) + 1;
            pulse(n, e_cor);
            check(pin(), 8'h00, "pin cor");
            rd(lem_pkg::ADDR_CORRECTED);
            check(q, exp_cnt(n), "cor");
        end
        pulse(260, e_det);
        rd(lem_pkg::ADDR_DETECTED);
        check(q, exp_cnt(260), "sat");
        pulse(2, e_det);
        for (int i = 0; i < 16; i++)
        begin
            @(negedge clk);
            sym = 1'b1;
            cerr = (i % 4 == 3);
        end
        @(negedge clk);
        sym = 1'b0;
        cerr = 1'b0;
        wait_hi(1'b1);
        wait_hi(1'b0);
        rd(lem_pkg::ADDR_DETECTED);
        check(q, 8'h00, "lock clear");
        i_lem_mcu.access(1'b1, lem_pkg::ADDR_CONFIG, 8'h14, q);
        pulse(4, e_det);
        check(pin(), 8'h00, "pin auto");
        repeat (19) @(negedge clk);
        check(pin(), 8'h00, "auto early");
        repeat (2) @(negedge clk);
        check(pin(), 8'h01, "auto");
        rd(lem_pkg::ADDR_DETECTED);
        check(q, 8'h00, "auto cnt");
        i_lem_mcu.access(1'b1, lem_pkg::ADDR_CONFIG, 8'h34, q);
        pulse(3, e_det);
        rd(lem_pkg::ADDR_DETECTED);
        check(q, 8'h00, "test det");
        pulse(1, e_tst);
        check(pin(), 8'h00, "pin test");
        repeat (25) @(negedge clk);
        check(pin(), 8'h00, "no auto");
        rd(lem_pkg::ADDR_TEST_ERR);
        check(q, 8'h01, "test cnt");
        check(pin(), 8'h01, "test read");
        tally_and_finish();
    end
endmodule : link_error_monitor_tb_top
`default_nettype wire
